// *** hdl/ofs_top.sv ***
// Function
// RULE1 - terminal mode 0 pulse, 1 switch, default 0
// RULE2 - pulse output never above 100 Hz
// RULE3 - own code per output, defaults 0, 2, 4
// RULE4 - code 0 keeps terminal inactive
// RULE5 - code 1 on while running, zero included
// RULE6 - code 2 on after fault stop
// RULE7 - code 5 on at zero-speed run, off stopped
// RULE8 - code 6 on above motor pre-warning
// RULE9 - code 7 on 10 s before drive overload
// RULE10 - codes 8, 9 on at count reached
// RULE11 - code 10 on when length exceeds setpoint
// RULE12 - code 11 gives 250 ms pulse per cycle
// RULE13 - code 12 on past running-time threshold
// RULE14 - code 13 on when set and output limited
// RULE15 - code 14 on at torque limit stall
// RULE16 - code 15 on when ready to run
// RULE17 - code 16 on when first input exceeds second
// RULE18 - code 17 on at upper frequency limit
// RULE19 - code 18 on at lower limit, off stopped
// RULE20 - code 19 on during undervoltage
// RULE21 - code 23 on at zero frequency or stopped
// RULE22 - code 24 on past power-on threshold
// RULE23 - reserved or unimplemented codes stay inactive
`timescale 1ns/10ps
module ofs_top #(
    parameter int PULSE_MIN_HALF  = ofs_pkg::PULSE_MIN_HALF,
    parameter int CYCLE_PULSE_CYC = ofs_pkg::CYCLE_PULSE_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire ofs_pkg::ofs_avreq_t          avReq,
    output logic [ofs_pkg::DATA_W-1:0]        avReadData,
    output logic                              avWaitRequest,
    input  wire ofs_pkg::ofs_cond_t           cond,
    input  wire logic [ofs_pkg::AIN_W-1:0]    firstAnalogInput,
    input  wire logic [ofs_pkg::AIN_W-1:0]    secondAnalogInput,
    input  wire logic [ofs_pkg::TLEFT_W-1:0]  driveOverTimeLeftMs,
    output logic                              multiplexedTerminalOut,
    output logic                              relayOut,
    output logic                              openCollectorOut
);
    localparam int CW = ofs_pkg::CODE_W;
    localparam int DW = ofs_pkg::DATA_W;
    localparam int PW = ofs_pkg::PULSE_W;
    localparam int YW = ofs_pkg::CYC_W;
    localparam logic [PW-1:0] MIN_HALF = PW'(PULSE_MIN_HALF);
    localparam logic [YW-1:0] CYC_LEN  = YW'(CYCLE_PULSE_CYC);
    localparam logic [YW-1:0] CYC_ONE  = YW'(1);
    localparam logic [PW-1:0] PW_ONE   = PW'(1);

    logic               modeReg;
    logic [CW-1:0]      funcReg [ofs_pkg::OUTS];
    logic [PW-1:0]      pulseHalfReg;
    logic [PW-1:0]      pulseCntReg;
    logic               pulseLevelReg;
    logic [YW-1:0]      cycTimerReg;
    logic [ofs_pkg::OUTS-1:0] outReg;
    logic               muxTermReg;
    logic               waitReg;
    logic [DW-1:0]      readDataReg;
    logic [ofs_pkg::CODES-1:0] condVec;
    logic [ofs_pkg::OUTS-1:0]  selCond;
    logic [PW-1:0]      pulseCntNext;
    logic               pulseLevelNext;
    logic [YW-1:0]      cycTimerNext;
    wire  [CW-1:0]      rlyCode = funcReg[ofs_pkg::OUT_RELAY];

    // one clock and one reset for every check below
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // bus decode; one wait cycle per access keeps read data a clean flop
    wire            req       = avReq.read | avReq.write;
    wire            accept    = req & ~waitReg;
    wire            wrAccept  = accept & avReq.write;
    wire            waitNext  = ~(req & waitReg);
    wire            hitMode   = avReq.address == ofs_pkg::OFF_MODE;
    wire            hitSwitch = avReq.address == ofs_pkg::OFF_SWITCH;
    wire            hitRelay  = avReq.address == ofs_pkg::OFF_RELAY;
    wire            hitOc     = avReq.address == ofs_pkg::OFF_OC;
    wire            hitPulse  = avReq.address == ofs_pkg::OFF_PULSE;
    wire            hitStatus = avReq.address == ofs_pkg::OFF_STATUS;
    wire [DW-1:0]   beMask;

    // byte lanes widen into a bit mask
    genvar b;
    generate
        for (b = 0; b < ofs_pkg::BE_W; b++) begin : g_lane
            assign beMask[b*8 +: 8] = {8{avReq.byteenable[b]}};
        end
    endgenerate

    // current contents of each register as a full word
    wire [DW-1:0] modeWord   = DW'(modeReg);
    wire [DW-1:0] switchWord = DW'(funcReg[ofs_pkg::OUT_SWITCH]);
    wire [DW-1:0] relayWord  = DW'(funcReg[ofs_pkg::OUT_RELAY]);
    wire [DW-1:0] ocWord     = DW'(funcReg[ofs_pkg::OUT_OC]);
    wire [DW-1:0] pulseWord  = DW'(pulseHalfReg);
    wire [DW-1:0] statusWord = DW'({muxTermReg, (cycTimerReg != '0), pulseLevelReg, outReg});

    // unmapped offsets read as zero and ignore writes
    wire [DW-1:0] readWord =
        hitMode   ? modeWord   :
        hitSwitch ? switchWord :
        hitRelay  ? relayWord  :
        hitOc     ? ocWord     :
        hitPulse  ? pulseWord  :
        hitStatus ? statusWord : '0;

    // byte-enable merge of write data into the addressed word
    wire [DW-1:0] mergedWord = (readWord & ~beMask) | (avReq.writedata & beMask);

    // bus handshake and read data capture
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            waitReg     <= 1'b1;
            readDataReg <= '0;
        end else begin
            waitReg <= waitNext;
            if (req && waitReg) begin
                readDataReg <= readWord;
            end
        end
    end

    // configuration writes land on the edge that sees waitrequest low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            modeReg                      <= ofs_pkg::MODE_PULSE;   // RULE1
            funcReg[ofs_pkg::OUT_SWITCH] <= ofs_pkg::RST_SWITCH;   // RULE3
            funcReg[ofs_pkg::OUT_RELAY]  <= ofs_pkg::RST_RELAY;    // RULE3
            funcReg[ofs_pkg::OUT_OC]     <= ofs_pkg::RST_OC;       // RULE3
            pulseHalfReg                 <= ofs_pkg::RST_PULSE;
        end else if (wrAccept) begin
            if (hitMode) modeReg <= mergedWord[0];
            if (hitSwitch) funcReg[ofs_pkg::OUT_SWITCH] <= mergedWord[CW-1:0];
            if (hitRelay) funcReg[ofs_pkg::OUT_RELAY] <= mergedWord[CW-1:0];
            if (hitOc) funcReg[ofs_pkg::OUT_OC] <= mergedWord[CW-1:0];
            if (hitPulse) pulseHalfReg <= mergedWord[PW-1:0];
        end
    end

    // condition table; codes left at zero stay inactive
    always_comb begin
        condVec = '0;                                                       // RULE4 RULE23
        condVec[ofs_pkg::FN_RUN]        = cond.running;                     // RULE5
        condVec[ofs_pkg::FN_FAULT]      = cond.faultStop;                   // RULE6
        condVec[ofs_pkg::FN_ZERO_RUN]   = cond.running & cond.zeroFreq;     // RULE7
        condVec[ofs_pkg::FN_MOTOR_WARN] = cond.motorOverWarn;               // RULE8
        condVec[ofs_pkg::FN_DRIVE_WARN] = cond.driveOverActive &
            (driveOverTimeLeftMs <= ofs_pkg::TLEFT_W'(ofs_pkg::PREWARN_MS)); // RULE9
        condVec[ofs_pkg::FN_COUNT_SET]  = cond.countSetHit;                 // RULE10
        condVec[ofs_pkg::FN_COUNT_DES]  = cond.countDesHit;                 // RULE10
        condVec[ofs_pkg::FN_LENGTH]     = cond.lengthOver;                  // RULE11
        condVec[ofs_pkg::FN_CYCLE]      = cycTimerReg != '0;                // RULE12
        condVec[ofs_pkg::FN_RUN_TIME]   = cond.runTimeOver;                 // RULE13
        condVec[ofs_pkg::FN_FREQ_LIM]   = cond.setBeyondLimit &
            (cond.atUpperLimit | cond.atLowerLimit);                        // RULE14
        condVec[ofs_pkg::FN_TORQUE]     = cond.speedMode & cond.torqueAtLimit; // RULE15
        condVec[ofs_pkg::FN_READY]      = cond.ready;                       // RULE16
        condVec[ofs_pkg::FN_AIN_CMP]    = firstAnalogInput > secondAnalogInput; // RULE17
        condVec[ofs_pkg::FN_UPPER]      = cond.atUpperLimit;                // RULE18
        condVec[ofs_pkg::FN_LOWER]      = cond.running & cond.atLowerLimit; // RULE19
        condVec[ofs_pkg::FN_UNDERVOLT]  = cond.underVoltage;                // RULE20
        condVec[ofs_pkg::FN_ZERO_ALL]   = cond.zeroFreq | ~cond.running;    // RULE21
        condVec[ofs_pkg::FN_POWER_ON]   = cond.powerOnOver;                 // RULE22
    end

    // each output picks its own condition by its code
    genvar i;
    generate
        for (i = 0; i < ofs_pkg::OUTS; i++) begin : g_sel
            assign selCond[i] = condVec[funcReg[i]];                        // RULE3
        end
    endgenerate

    // pulse generator; the half period is floored so 100 Hz is never passed
    wire          pulseRun  = (modeReg == ofs_pkg::MODE_PULSE) && (pulseHalfReg != '0);
    wire [PW-1:0] halfEff   = (pulseHalfReg < MIN_HALF) ? MIN_HALF : pulseHalfReg; // RULE2
    always_comb begin
        pulseCntNext   = pulseCntReg - PW_ONE;
        pulseLevelNext = pulseLevelReg;
        if (!pulseRun) begin
            pulseCntNext   = '0;
            pulseLevelNext = 1'b0;
        end else if (pulseCntReg == '0) begin
            pulseCntNext   = halfEff - PW_ONE;                              // RULE2
            pulseLevelNext = ~pulseLevelReg;
        end
    end

    // cycle-complete pulse timer; a new cycle end restarts the width
    always_comb begin
        cycTimerNext = (cycTimerReg != '0) ? cycTimerReg - CYC_ONE : '0;
        if (cond.cycleDone) begin
            cycTimerNext = CYC_LEN;                                         // RULE12
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pulseCntReg   <= '0;
            pulseLevelReg <= 1'b0;
            cycTimerReg   <= '0;
        end else begin
            pulseCntReg   <= pulseCntNext;
            pulseLevelReg <= pulseLevelNext;
            cycTimerReg   <= cycTimerNext;
        end
    end

    // terminal flops; the shared terminal follows its mode
    wire muxTermNext = (modeReg == ofs_pkg::MODE_SWITCH) ?
                       selCond[ofs_pkg::OUT_SWITCH] : pulseLevelReg;        // RULE1
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            outReg     <= '0;
            muxTermReg <= 1'b0;
        end else begin
            outReg     <= selCond;
            muxTermReg <= muxTermNext;
        end
    end

    assign avReadData             = readDataReg;
    assign avWaitRequest          = waitReg;
    assign multiplexedTerminalOut = muxTermReg;
    assign relayOut               = outReg[ofs_pkg::OUT_RELAY];
    assign openCollectorOut       = outReg[ofs_pkg::OUT_OC];

    // helper: cycles since the pulse level last changed
    logic [PW-1:0] sinceToggle;
    always_ff @(posedge clk) begin
        if (!reset_n || !pulseRun || (pulseLevelNext != pulseLevelReg)) begin
            sinceToggle <= '0;
        end else begin
            sinceToggle <= sinceToggle + PW_ONE;
        end
    end

    pulse_rate_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        (pulseRun && (pulseLevelNext != pulseLevelReg) && sinceToggle != '0)
        |-> sinceToggle >= MIN_HALF - PW_ONE)
        else $error("pulse half period shorter than the limit");

    switch_mode_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
        (modeReg == ofs_pkg::MODE_SWITCH && $stable(modeReg))
        |=> multiplexedTerminalOut == $past(selCond[ofs_pkg::OUT_SWITCH]))
        else $error("switch mode terminal does not follow its condition");

    code_none_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
        (funcReg[ofs_pkg::OUT_RELAY] == '0) |=> !relayOut)
        else $error("relay active with code zero");

    fault_relay_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
        (funcReg[ofs_pkg::OUT_RELAY] == CW'(ofs_pkg::FN_FAULT))
        |=> relayOut == $past(cond.faultStop))
        else $error("relay does not show fault stop");

    cycle_width_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        cond.cycleDone |=> (cycTimerReg != '0) [*8])
        else $error("cycle pulse ended too soon");

    cycle_end_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        (cycTimerReg == CYC_ONE && !cond.cycleDone) |=> cycTimerReg == '0)
        else $error("cycle pulse runs past its width");

    zero_stop_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
        (funcReg[ofs_pkg::OUT_OC] == CW'(ofs_pkg::FN_ZERO_RUN) && !cond.running)
        |=> !openCollectorOut)
        else $error("zero speed output on while stopped");

    zero_all_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE21
        (funcReg[ofs_pkg::OUT_OC] == CW'(ofs_pkg::FN_ZERO_ALL) && !cond.running)
        |=> openCollectorOut)
        else $error("zero speed two output off while stopped");

    reserved_code_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE23
        (funcReg[ofs_pkg::OUT_OC] > CW'(ofs_pkg::FN_POWER_ON)) |=> !openCollectorOut)
        else $error("reserved code drives the terminal");

    bus_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
        (req && avWaitRequest) |=> !avWaitRequest ##1 avWaitRequest)
        else $error("bus answer not given in one wait cycle");

    run_code_a: assert property ( // RULE5
        rlyCode == CW'(ofs_pkg::FN_RUN)
        |=> relayOut == $past(cond.running))
        else $error("relay misses running");

    motor_warn_a: assert property ( // RULE8
        rlyCode == CW'(ofs_pkg::FN_MOTOR_WARN)
        |=> relayOut == $past(cond.motorOverWarn))
        else $error("relay misses motor warning");

    count_set_a: assert property ( // RULE10
        rlyCode == CW'(ofs_pkg::FN_COUNT_SET)
        |=> relayOut == $past(cond.countSetHit))
        else $error("relay misses count");

    length_over_a: assert property ( // RULE11
        rlyCode == CW'(ofs_pkg::FN_LENGTH)
        |=> relayOut == $past(cond.lengthOver))
        else $error("relay misses length");

    run_time_a: assert property ( // RULE13
        rlyCode == CW'(ofs_pkg::FN_RUN_TIME)
        |=> relayOut == $past(cond.runTimeOver))
        else $error("relay misses running time");

    torque_stall_a: assert property ( // RULE15
        rlyCode == CW'(ofs_pkg::FN_TORQUE)
        |=> relayOut == ($past(cond.speedMode) & $past(cond.torqueAtLimit)))
        else $error("relay misses torque limit");

    ready_run_a: assert property ( // RULE16
        rlyCode == CW'(ofs_pkg::FN_READY)
        |=> relayOut == $past(cond.ready))
        else $error("relay misses ready");

    input_compare_a: assert property ( // RULE17
        rlyCode == CW'(ofs_pkg::FN_AIN_CMP)
        |=> relayOut == ($past(firstAnalogInput) > $past(secondAnalogInput)))
        else $error("relay misses input compare");

    upper_limit_a: assert property ( // RULE18
        rlyCode == CW'(ofs_pkg::FN_UPPER)
        |=> relayOut == $past(cond.atUpperLimit))
        else $error("relay misses upper limit");

    under_volt_a: assert property ( // RULE20
        rlyCode == CW'(ofs_pkg::FN_UNDERVOLT)
        |=> relayOut == $past(cond.underVoltage))
        else $error("relay misses undervoltage");

    power_on_a: assert property ( // RULE22
        rlyCode == CW'(ofs_pkg::FN_POWER_ON)
        |=> relayOut == $past(cond.powerOnOver))
        else $error("relay misses power-on time");
endmodule

// *** hdl/ofs_pkg.sv ***
package ofs_pkg;
    // clock and documented timing
    localparam int CLK_HZ         = 125_000_000;
    localparam int PULSE_MAX_HZ   = 100;
    localparam int CYCLE_PULSE_MS = 250;
    localparam int PREWARN_MS     = 10_000;
    // least half period rounds up so the pulse never beats the limit
    localparam int PULSE_MIN_HALF  = (CLK_HZ + 2 * PULSE_MAX_HZ - 1) / (2 * PULSE_MAX_HZ);
    localparam int CYCLE_PULSE_CYC = CLK_HZ / 1000 * CYCLE_PULSE_MS;

    // widths
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int BE_W    = 4;
    localparam int CODE_W  = 5;
    localparam int CODES   = 32;
    localparam int PULSE_W = 24;
    localparam int CYC_W   = 25;
    localparam int AIN_W   = 12;
    localparam int TLEFT_W = 16;
    localparam int OUTS    = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SWITCH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RELAY  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_OC     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PULSE  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;

    // terminal mode and reset values
    localparam logic              MODE_PULSE  = 1'b0;
    localparam logic              MODE_SWITCH = 1'b1;
    localparam logic [CODE_W-1:0] RST_SWITCH  = 5'h00;
    localparam logic [CODE_W-1:0] RST_RELAY   = 5'h02;
    localparam logic [CODE_W-1:0] RST_OC      = 5'h04;
    localparam logic [PULSE_W-1:0] RST_PULSE  = 24'h000000;

    // output index and status field positions
    localparam int OUT_SWITCH = 0;
    localparam int OUT_RELAY  = 1;
    localparam int OUT_OC     = 2;
    localparam int ST_OUTS    = 0;
    localparam int ST_PULSE   = 3;
    localparam int ST_CYCLE   = 4;
    localparam int ST_MUX     = 5;

    // function codes
    localparam int FN_RUN        = 1;
    localparam int FN_FAULT      = 2;
    localparam int FN_ZERO_RUN   = 5;
    localparam int FN_MOTOR_WARN = 6;
    localparam int FN_DRIVE_WARN = 7;
    localparam int FN_COUNT_SET  = 8;
    localparam int FN_COUNT_DES  = 9;
    localparam int FN_LENGTH     = 10;
    localparam int FN_CYCLE      = 11;
    localparam int FN_RUN_TIME   = 12;
    localparam int FN_FREQ_LIM   = 13;
    localparam int FN_TORQUE     = 14;
    localparam int FN_READY      = 15;
    localparam int FN_AIN_CMP    = 16;
    localparam int FN_UPPER      = 17;
    localparam int FN_LOWER      = 18;
    localparam int FN_UNDERVOLT  = 19;
    localparam int FN_ZERO_ALL   = 23;
    localparam int FN_POWER_ON   = 24;

    // drive conditions from the drive core
    typedef struct packed {
        logic running;
        logic zeroFreq;
        logic faultStop;
        logic motorOverWarn;
        logic driveOverActive;
        logic countSetHit;
        logic countDesHit;
        logic lengthOver;
        logic cycleDone;
        logic runTimeOver;
        logic setBeyondLimit;
        logic atUpperLimit;
        logic atLowerLimit;
        logic torqueAtLimit;
        logic speedMode;
        logic ready;
        logic underVoltage;
        logic powerOnOver;
    } ofs_cond_t;

    // avalon request from the master
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [BE_W-1:0]   byteenable;
        logic [DATA_W-1:0] writedata;
    } ofs_avreq_t;
endpackage

// *** test/ofs_reader.sv ***
`timescale 1ns/10ps
// far-side reader: measures how long a terminal stays at each level
module ofs_reader (
    input  wire logic        clk,
    input  wire logic        line,
    output logic      [31:0] lastHigh,
    output logic      [31:0] lastLow
);
    logic [31:0] runLenReg = 32'h0;
    logic        levelReg  = 1'b0;

    // run length latched on each change; an unknown level also counts as a change
    always @(posedge clk) begin
        if (line !== levelReg) begin
            if (levelReg === 1'b1) begin
                lastHigh <= runLenReg;
            end else begin
                lastLow <= runLenReg;
            end
            runLenReg <= 32'h1;
        end else begin
            runLenReg <= runLenReg + 32'h1;
        end
        levelReg <= line;
    end
endmodule

// *** test/tb.sv ***
`timescale 1ns/10ps
module tb;
    localparam int HALF_MIN = 8;
    localparam int WIN      = 16;
    logic                clk                 = 1'b0;
    logic                reset_n             = 1'b0;
    ofs_pkg::ofs_avreq_t avReq               = '0;
    ofs_pkg::ofs_cond_t  cond                = '0;
    logic [11:0]         firstAnalogInput    = 12'h800;
    logic [11:0]         secondAnalogInput   = 12'h800;
    logic [15:0]         driveOverTimeLeftMs = 16'h2710;
    logic [31:0]         avReadData;
    logic                avWaitRequest;
    logic                multiplexedTerminalOut;
    logic                relayOut;
    logic                openCollectorOut;
    logic [31:0]         muxHigh, muxLow, relayHigh;
    logic [31:0]         rdata;
    ofs_pkg::ofs_cond_t  pc;
    logic                e;
    int                  n_mismatch   = 0;
    int                  total_checks = 0;

    always #4 clk = ~clk;

    // short counts keep the run small; expectations use the same values
    ofs_top #(.PULSE_MIN_HALF(HALF_MIN), .CYCLE_PULSE_CYC(WIN)) ofs_top_inst (
        .clk(clk), .reset_n(reset_n), .avReq(avReq), .avReadData(avReadData),
        .avWaitRequest(avWaitRequest), .cond(cond), .firstAnalogInput(firstAnalogInput),
        .secondAnalogInput(secondAnalogInput), .driveOverTimeLeftMs(driveOverTimeLeftMs),
        .multiplexedTerminalOut(multiplexedTerminalOut), .relayOut(relayOut),
        .openCollectorOut(openCollectorOut));
    ofs_reader mux_reader_inst (.clk(clk), .line(multiplexedTerminalOut),
        .lastHigh(muxHigh), .lastLow(muxLow));
    ofs_reader relay_reader_inst (.clk(clk), .line(relayOut),
        .lastHigh(relayHigh), .lastLow());

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    // one avalon access; request held until waitrequest is sampled low
    task automatic access(input logic rd, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avReq <= '{read: rd, write: !rd, address: addr, byteenable: 4'hf, writedata: wd};
        do begin
            @(posedge clk);
            n++;
        end while (avWaitRequest !== 1'b0 && n < 40);
        rdata = avReadData;
        avReq <= '0;
        if (n >= 40) check("waitrequest", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        access(1'b0, addr, wd);
    endtask

    task automatic rd(input string what, input logic [7:0] addr, input logic [31:0] want);
        access(1'b1, addr, 32'h0);
        check(what, rdata, want);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // condition pattern table: one-hot bits, none, all, and telling mixes
    function automatic ofs_pkg::ofs_cond_t pat(input int p);
        ofs_pkg::ofs_cond_t c;
        c = '0;
        if (p < 18) c = ofs_pkg::ofs_cond_t'(18'h1 << p);
        if (p == 19) c = '1;
        if (p == 20) c = '{setBeyondLimit: 1'b1, atLowerLimit: 1'b1, default: 1'b0};
        if (p == 21) c = '{running: 1'b1, zeroFreq: 1'b1, atLowerLimit: 1'b1, default: 1'b0};
        if (p == 22) c = '{driveOverActive: 1'b1, default: 1'b0};
        if (p == 23) c = '{torqueAtLimit: 1'b1, speedMode: 1'b1, default: 1'b0};
        return c;
    endfunction

    function automatic logic want(input int code, input ofs_pkg::ofs_cond_t c,
                                  input logic gt, input logic [15:0] left);
        case (code)
            ofs_pkg::FN_RUN:        return c.running;
            ofs_pkg::FN_FAULT:      return c.faultStop;
            ofs_pkg::FN_ZERO_RUN:   return c.running & c.zeroFreq;
            ofs_pkg::FN_MOTOR_WARN: return c.motorOverWarn;
            ofs_pkg::FN_DRIVE_WARN: return c.driveOverActive & (left <= 16'h2710);
            ofs_pkg::FN_COUNT_SET:  return c.countSetHit;
            ofs_pkg::FN_COUNT_DES:  return c.countDesHit;
            ofs_pkg::FN_LENGTH:     return c.lengthOver;
            ofs_pkg::FN_RUN_TIME:   return c.runTimeOver;
            ofs_pkg::FN_FREQ_LIM:   return c.setBeyondLimit & (c.atUpperLimit | c.atLowerLimit);
            ofs_pkg::FN_TORQUE:     return c.torqueAtLimit & c.speedMode;
            ofs_pkg::FN_READY:      return c.ready;
            ofs_pkg::FN_AIN_CMP:    return gt;
            ofs_pkg::FN_UPPER:      return c.atUpperLimit;
            ofs_pkg::FN_LOWER:      return c.atLowerLimit & c.running;
            ofs_pkg::FN_UNDERVOLT:  return c.underVoltage;
            ofs_pkg::FN_ZERO_ALL:   return c.zeroFreq | !c.running;
            ofs_pkg::FN_POWER_ON:   return c.powerOnOver;
            default:                return 1'b0;
        endcase
    endfunction

    // hang guard, about five times the expected run
    initial begin
        repeat (10000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // reset values and an unmapped place
        settle(0);
        check("mux after reset", multiplexedTerminalOut, 32'h0);
        rd("mode", ofs_pkg::OFF_MODE, 32'h0);
        rd("switch code", ofs_pkg::OFF_SWITCH, 32'h0);
        rd("relay code", ofs_pkg::OFF_RELAY, 32'h2);
        rd("oc code", ofs_pkg::OFF_OC, 32'h4);
        wr(8'h20, 32'h1f);
        rd("unmapped", 8'h20, 32'h0);
        // default codes: fault drives relay, code 4 stays idle
        @(posedge clk);
        cond <= '{faultStop: 1'b1, default: 1'b0};
        settle(1);
        check("relay default", relayOut, 32'h1);
        check("oc default", openCollectorOut, 32'h0);
        $display("test reset done");

        // every code but 11 (cycle pulse) against every pattern, same code on all three outputs
        wr(ofs_pkg::OFF_MODE, 32'h1);
        for (int code = 0; code < 32; code++) begin
            if (code != ofs_pkg::FN_CYCLE) begin
                wr(ofs_pkg::OFF_SWITCH, code);
                wr(ofs_pkg::OFF_RELAY, code);
                wr(ofs_pkg::OFF_OC, code);
                for (int p = 0; p < 24; p++) begin
                    pc = pat(p);
                    @(posedge clk);
                    cond <= pc;
                    firstAnalogInput <= (p == 19) ? 12'h801 : (p == 20) ? 12'h7ff : 12'h800;
                    driveOverTimeLeftMs <= (p == 22) ? 16'h2711 : 16'h2710;
                    settle(1);
                    e = want(code, pc, p == 19, (p == 22) ? 16'h2711 : 16'h2710);
                    check($sformatf("relay c%0d p%0d", code, p), relayOut, e);
                    check($sformatf("oc c%0d p%0d", code, p), openCollectorOut, e);
                    check($sformatf("sw c%0d p%0d", code, p), multiplexedTerminalOut, e);
                end
            end
        end
        $display("test code table done");

        // independent codes per output
        wr(ofs_pkg::OFF_SWITCH, 32'h1);
        wr(ofs_pkg::OFF_RELAY, 32'h2);
        wr(ofs_pkg::OFF_OC, 32'h13);
        @(posedge clk);
        cond <= '{running: 1'b1, default: 1'b0};
        settle(1);
        check("sw own", multiplexedTerminalOut, 32'h1);
        check("relay own", relayOut, 32'h0);
        check("oc own", openCollectorOut, 32'h0);
        $display("test independent done");

        // cycle-complete pulse width
        wr(ofs_pkg::OFF_RELAY, ofs_pkg::FN_CYCLE);
        @(posedge clk);
        cond <= '{cycleDone: 1'b1, default: 1'b0};
        @(posedge clk);
        cond <= '0;
        settle(0);
        check("cycle not early", relayOut, 32'h0);
        settle(WIN + 10);
        check("cycle width", relayHigh, WIN);
        check("cycle ended", relayOut, 32'h0);
        $display("test cycle pulse done");

        // pulse mode ignores switch code, then frequency is capped
        @(posedge clk);
        cond <= '{running: 1'b1, default: 1'b0};
        wr(ofs_pkg::OFF_MODE, 32'h0);
        settle(6);
        check("pulse off", multiplexedTerminalOut, 32'h0);
        wr(ofs_pkg::OFF_PULSE, 32'h3);
        settle(6 * HALF_MIN);
        check("high capped", muxHigh, HALF_MIN);
        check("low capped", muxLow, HALF_MIN);
        wr(ofs_pkg::OFF_PULSE, 32'hc);
        settle(80);
        check("high slow", muxHigh, 32'hc);
        check("low slow", muxLow, 32'hc);
        wr(ofs_pkg::OFF_MODE, 32'h1);
        settle(3);
        check("switch mode", multiplexedTerminalOut, 32'h1);
        rd("pulse half", ofs_pkg::OFF_PULSE, 32'hc);
        rd("status", ofs_pkg::OFF_STATUS, 32'h21);
        $display("test pulse done");
        stop_test();
    end
endmodule
